// ===== hdl/tsc_pkg.sv
/*
 * constants and carrier types for the twin serial channels block.
 * assumes one 250 MHz system clock; the serial clock source is a pin sampled on it.
 */
package tsc_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_CH = 2;
    localparam int unsigned OVS = 16;
    localparam int unsigned OVS_MID = 7;
    localparam int unsigned CNT_W = 4;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic LINE_START = 1'b0;

    typedef enum logic [3:0] {
        TSC_IDLE = 4'h1,
        TSC_START = 4'h2,
        TSC_DATA = 4'h4,
        TSC_STOP = 4'h8
    } tsc_state_t;

    typedef struct packed {
        logic enable;
        logic loopback;
    } tsc_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } tsc_word_t;
endpackage

// ===== hdl/tsc_twin_serial_channels.sv
/*
 * two asynchronous serial channels with request/grant handshake.
 * assumes the serial clock source toggles at most every second system clock;
 * one bit lasts OVS serial clock periods.
 */
`timescale 1ns/1ps
module tsc_channel #(
    parameter int unsigned DATA_W = tsc_pkg::DATA_W
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // serial clock source edges (already synchronised)
    input wire logic sclk_rise,
    input wire logic sclk_fall,
    // control
    input wire tsc_pkg::tsc_ctrl_t ctrl,
    // transmit word stream
    input wire logic tx_valid,
    input wire logic [DATA_W-1:0] tx_data,
    output logic tx_ready,
    // received word
    output tsc_pkg::tsc_word_t rx_word,
    // pins (rx and grant already synchronised)
    input wire logic serial_in,
    input wire logic send_grant,
    output logic serial_out,
    output logic send_request
);
    localparam int unsigned BIT_W = $clog2(DATA_W);

    // the received word carrier is fixed at the package width
    if (DATA_W != tsc_pkg::DATA_W)
    begin : g_width_chk
        $error("tsc_channel: DATA_W must match the package word width");
    end

    // two-entry skid buffer in front of the transmitter
    logic [DATA_W-1:0] buf_ff [2];
    logic [DATA_W-1:0] nxt_buf [2];
    logic [1:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy;
    logic pop;

    tsc_pkg::tsc_state_t tx_st_ff, nxt_tx_st;
    logic [DATA_W-1:0] tx_sh_ff, nxt_tx_sh;
    logic [BIT_W-1:0] tx_bit_ff, nxt_tx_bit;
    logic [tsc_pkg::CNT_W-1:0] tx_ov_ff, nxt_tx_ov;
    logic line_ff, nxt_line;
    logic out_ff, nxt_out;
    logic rts_ff, nxt_rts;

    tsc_pkg::tsc_state_t rx_st_ff, nxt_rx_st;
    logic [DATA_W-1:0] rx_sh_ff, nxt_rx_sh;
    logic [BIT_W-1:0] rx_bit_ff, nxt_rx_bit;
    logic [tsc_pkg::CNT_W-1:0] rx_ov_ff, nxt_rx_ov;
    tsc_pkg::tsc_word_t rxw_ff, nxt_rxw;
    logic rx_src;

    always_comb
    begin
        nxt_buf = buf_ff;
        nxt_cnt = cnt_ff;
        if (pop)
        begin
            nxt_buf[0] = buf_ff[1];
            nxt_cnt = cnt_ff - 2'h1;
        end
        if (tx_valid && tx_ready)
        begin
            nxt_buf[nxt_cnt[0]] = tx_data;
            nxt_cnt = nxt_cnt + 2'h1;
        end
        nxt_rdy = (nxt_cnt != 2'h2);
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            buf_ff[0] <= '0;
            buf_ff[1] <= '0;
            cnt_ff <= 2'h0;
            rdy_ff <= 1'b1;
        end
        else
        begin
            buf_ff <= nxt_buf;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
        end
    end

    // ready is a flop that mirrors the count, so the port comes straight from a register
    assign tx_ready = rdy_ff;

    // transmitter: all line changes happen on the falling edge of the serial clock
    always_comb
    begin
        nxt_tx_st = tx_st_ff;
        nxt_tx_sh = tx_sh_ff;
        nxt_tx_bit = tx_bit_ff;
        nxt_tx_ov = tx_ov_ff;
        nxt_line = line_ff;
        pop = 1'b0;
        nxt_rts = ctrl.enable && (cnt_ff != 2'h0);
        if (sclk_fall)
        begin
            nxt_tx_ov = tx_ov_ff + tsc_pkg::CNT_W'(1'b1);
            unique case (tx_st_ff)
                tsc_pkg::TSC_IDLE:
                begin
                    nxt_line = tsc_pkg::LINE_IDLE;
                    nxt_tx_ov = '0;
                    if (ctrl.enable && cnt_ff != 2'h0 && send_grant)
                    begin
                        nxt_tx_sh = buf_ff[0];
                        pop = 1'b1;
                        nxt_line = tsc_pkg::LINE_START;
                        nxt_tx_st = tsc_pkg::TSC_START;
                    end
                end
                tsc_pkg::TSC_START:
                begin
                    if (tx_ov_ff == tsc_pkg::CNT_W'(tsc_pkg::OVS - 1))
                    begin
                        nxt_line = tx_sh_ff[0];
                        nxt_tx_bit = '0;
                        nxt_tx_st = tsc_pkg::TSC_DATA;
                    end
                end
                tsc_pkg::TSC_DATA:
                begin
                    if (tx_ov_ff == tsc_pkg::CNT_W'(tsc_pkg::OVS - 1))
                    begin
                        nxt_tx_sh = tx_sh_ff >> 1;
                        if (tx_bit_ff == BIT_W'(DATA_W - 1))
                        begin
                            nxt_line = tsc_pkg::LINE_IDLE;
                            nxt_tx_st = tsc_pkg::TSC_STOP;
                        end
                        else
                        begin
                            nxt_line = tx_sh_ff[1];
                            nxt_tx_bit = tx_bit_ff + BIT_W'(1'b1);
                        end
                    end
                end
                tsc_pkg::TSC_STOP:
                begin
                    if (tx_ov_ff == tsc_pkg::CNT_W'(tsc_pkg::OVS - 1))
                        nxt_tx_st = tsc_pkg::TSC_IDLE;
                end
                default:
                    nxt_tx_st = tsc_pkg::TSC_IDLE;
            endcase
        end
        // pin is high when disabled or looping back; loopback keeps data inside
        nxt_out = (ctrl.enable && !ctrl.loopback) ? nxt_line : tsc_pkg::LINE_IDLE;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_st_ff <= tsc_pkg::TSC_IDLE;
            tx_sh_ff <= '0;
            tx_bit_ff <= '0;
            tx_ov_ff <= '0;
            line_ff <= tsc_pkg::LINE_IDLE;
            out_ff <= tsc_pkg::LINE_IDLE;
            rts_ff <= 1'b0;
        end
        else
        begin
            tx_st_ff <= nxt_tx_st;
            tx_sh_ff <= nxt_tx_sh;
            tx_bit_ff <= nxt_tx_bit;
            tx_ov_ff <= nxt_tx_ov;
            line_ff <= nxt_line;
            out_ff <= nxt_out;
            rts_ff <= nxt_rts;
        end
    end

    assign serial_out = out_ff;
    assign send_request = rts_ff;

    // receiver: samples on rising edges, mid-bit after a start edge
    assign rx_src = ctrl.loopback ? line_ff : serial_in;

    always_comb
    begin
        nxt_rx_st = rx_st_ff;
        nxt_rx_sh = rx_sh_ff;
        nxt_rx_bit = rx_bit_ff;
        nxt_rx_ov = rx_ov_ff;
        nxt_rxw = '{valid: 1'b0, data: rxw_ff.data};
        if (sclk_rise && ctrl.enable)
        begin
            nxt_rx_ov = rx_ov_ff + tsc_pkg::CNT_W'(1'b1);
            unique case (rx_st_ff)
                tsc_pkg::TSC_IDLE:
                begin
                    nxt_rx_ov = '0;
                    if (rx_src == tsc_pkg::LINE_START)
                        nxt_rx_st = tsc_pkg::TSC_START;
                end
                tsc_pkg::TSC_START:
                begin
                    if (rx_ov_ff == tsc_pkg::CNT_W'(tsc_pkg::OVS_MID))
                    begin
                        nxt_rx_ov = '0;
                        nxt_rx_bit = '0;
                        // a glitch that is high at mid-bit is not a start bit
                        nxt_rx_st = (rx_src == tsc_pkg::LINE_START) ?
                            tsc_pkg::TSC_DATA : tsc_pkg::TSC_IDLE;
                    end
                end
                tsc_pkg::TSC_DATA:
                begin
                    if (rx_ov_ff == tsc_pkg::CNT_W'(tsc_pkg::OVS - 1))
                    begin
                        nxt_rx_sh[rx_bit_ff] = rx_src;
                        nxt_rx_bit = rx_bit_ff + BIT_W'(1'b1);
                        if (rx_bit_ff == BIT_W'(DATA_W - 1))
                            nxt_rx_st = tsc_pkg::TSC_STOP;
                    end
                end
                tsc_pkg::TSC_STOP:
                begin
                    if (rx_ov_ff == tsc_pkg::CNT_W'(tsc_pkg::OVS - 1))
                    begin
                        // framing error: word dropped when stop bit is low
                        nxt_rxw = '{valid: (rx_src == tsc_pkg::LINE_IDLE), data: rx_sh_ff};
                        nxt_rx_st = tsc_pkg::TSC_IDLE;
                    end
                end
                default:
                    nxt_rx_st = tsc_pkg::TSC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_st_ff <= tsc_pkg::TSC_IDLE;
            rx_sh_ff <= '0;
            rx_bit_ff <= '0;
            rx_ov_ff <= '0;
            rxw_ff <= '0;
        end
        else
        begin
            rx_st_ff <= nxt_rx_st;
            rx_sh_ff <= nxt_rx_sh;
            rx_bit_ff <= nxt_rx_bit;
            rx_ov_ff <= nxt_rx_ov;
            rxw_ff <= nxt_rxw;
        end
    end

    assign rx_word = rxw_ff;
endmodule

module tsc_twin_serial_channels
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // serial clock source pin
    input wire logic serial_clk,
    // per-channel control
    input wire tsc_pkg::tsc_ctrl_t ctrl_ch0,
    input wire tsc_pkg::tsc_ctrl_t ctrl_ch1,
    // transmit streams
    input wire logic tx_valid_ch0,
    input wire logic [tsc_pkg::DATA_W-1:0] tx_data_ch0,
    output logic tx_ready_ch0,
    input wire logic tx_valid_ch1,
    input wire logic [tsc_pkg::DATA_W-1:0] tx_data_ch1,
    output logic tx_ready_ch1,
    // received words
    output tsc_pkg::tsc_word_t rx_word_ch0,
    output tsc_pkg::tsc_word_t rx_word_ch1,
    // channel 0 pins
    input wire logic serial_in_ch0,
    input wire logic send_grant_ch0,
    output logic serial_out_ch0,
    output logic send_request_ch0,
    // channel 1 pins
    input wire logic serial_in_ch1,
    input wire logic send_grant_ch1,
    output logic serial_out_ch1,
    output logic send_request_ch1
);
    // five pin inputs, each through two flops; bit 0 is the serial clock
    // grants reset low so no frame can start before a real grant has been seen
    localparam logic [4:0] PIN_RST =
        {1'b0, tsc_pkg::LINE_IDLE, 1'b0, tsc_pkg::LINE_IDLE, 1'b1};
    logic [4:0] meta_ff, sync_ff;
    logic last_ff;
    logic rise, fall;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_ff <= PIN_RST;
            sync_ff <= PIN_RST;
            last_ff <= 1'b1;
        end
        else
        begin
            meta_ff <= {send_grant_ch1, serial_in_ch1, send_grant_ch0, serial_in_ch0, serial_clk};
            sync_ff <= meta_ff;
            last_ff <= sync_ff[0];
        end
    end

    assign rise = sync_ff[0] && !last_ff;
    assign fall = !sync_ff[0] && last_ff;

    // two identical independent channels
    tsc_channel u_ch0 (
        .clk_sys(clk_sys), .nrst(nrst), .sclk_rise(rise), .sclk_fall(fall),
        .ctrl(ctrl_ch0), .tx_valid(tx_valid_ch0), .tx_data(tx_data_ch0),
        .tx_ready(tx_ready_ch0), .rx_word(rx_word_ch0), .serial_in(sync_ff[1]),
        .send_grant(sync_ff[2]), .serial_out(serial_out_ch0), .send_request(send_request_ch0)
    );

    tsc_channel u_ch1 (
        .clk_sys(clk_sys), .nrst(nrst), .sclk_rise(rise), .sclk_fall(fall),
        .ctrl(ctrl_ch1), .tx_valid(tx_valid_ch1), .tx_data(tx_data_ch1),
        .tx_ready(tx_ready_ch1), .rx_word(rx_word_ch1), .serial_in(sync_ff[3]),
        .send_grant(sync_ff[4]), .serial_out(serial_out_ch1), .send_request(send_request_ch1)
    );
endmodule

// ===== dv/tsc_asserts.sv
/* checker for the twin serial channel pins, bound to the top module.
   assumes a serial clock of 8 system clocks, so one bit is 128 cycles. */
`timescale 1ns/1ps
module tsc_asserts
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // watched ports
    input wire tsc_pkg::tsc_ctrl_t ctrl_ch0,
    input wire tsc_pkg::tsc_ctrl_t ctrl_ch1,
    input wire logic tx_ready_ch0,
    input wire tsc_pkg::tsc_word_t rx_word_ch0,
    input wire logic serial_in_ch0,
    input wire logic send_grant_ch0,
    input wire logic serial_out_ch0,
    input wire logic serial_out_ch1,
    input wire logic send_request_ch0
);
    // margin below 128 covers synchroniser jitter
    localparam int HOLD_MIN = 120;
    // a frame's last data fall comes before this, the next start bit after it
    localparam int FRAME_CYC = 1200;
    logic [7:0] hold_ff;
    logic [7:0] nxt_hold;
    logic last_ff;
    logic [10:0] frm_ff;
    logic [10:0] nxt_frm;
    logic start_seen;
    always_comb
    begin
        nxt_hold = (serial_out_ch0 != last_ff) ? 8'h00 : hold_ff + {7'h00, hold_ff != 8'hFF};
        start_seen = last_ff && !serial_out_ch0 && (frm_ff == 11'h000);
        if (start_seen)
            nxt_frm = 11'(FRAME_CYC);
        else if (frm_ff != 11'h000)
            nxt_frm = frm_ff - 11'h001;
        else
            nxt_frm = frm_ff;
    end
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            // the line counts as long idle out of reset
            hold_ff <= 8'hFF;
            last_ff <= 1'b1;
            frm_ff <= 11'h000;
        end
        else
        begin
            hold_ff <= nxt_hold;
            last_ff <= serial_out_ch0;
            frm_ff <= nxt_frm;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    dis_idle_a: assert property (!ctrl_ch0.enable && !$past(ctrl_ch0.enable) |-> serial_out_ch0)
        else $error("ch0 line low while disabled");
    dis_idle1_a: assert property (!ctrl_ch1.enable && !$past(ctrl_ch1.enable) |-> serial_out_ch1)
        else $error("ch1 line low while disabled");
    loop_high_a: assert property (ctrl_ch0.loopback && $past(ctrl_ch0.loopback) |-> serial_out_ch0)
        else $error("line low in loopback");
    req_off_a: assert property (!$past(ctrl_ch0.enable) |-> !send_request_ch0)
        else $error("request while disabled");
    full_req_a: assert property (!tx_ready_ch0 && ctrl_ch0.enable && $past(ctrl_ch0.enable)
        |-> send_request_ch0)
        else $error("buffer full without request");
    // grant pin reaches the start decision three edges before the start bit shows
    no_grant_a: assert property (start_seen |-> $past(send_grant_ch0, 3))
        else $error("frame started without grant");
    bit_hold_a: assert property ((serial_out_ch0 != last_ff) |-> hold_ff >= HOLD_MIN)
        else $error("line level held too short");
    rx_stop_a: assert property (rx_word_ch0.valid && !ctrl_ch0.loopback
        |-> serial_in_ch0 && $past(serial_in_ch0, 3))
        else $error("word taken without high stop bit");
    cover property (rx_word_ch0.valid);
    cover property (!tx_ready_ch0);
    cover property ($fell(serial_out_ch0));
endmodule

bind tsc_twin_serial_channels tsc_asserts u_chk (.clk_sys(clk_sys), .nrst(nrst),
    .ctrl_ch0(ctrl_ch0), .ctrl_ch1(ctrl_ch1), .tx_ready_ch0(tx_ready_ch0),
    .rx_word_ch0(rx_word_ch0), .serial_in_ch0(serial_in_ch0), .send_grant_ch0(send_grant_ch0),
    .serial_out_ch0(serial_out_ch0), .serial_out_ch1(serial_out_ch1),
    .send_request_ch0(send_request_ch0));

// ===== dv/tsc_peer.sv
/* model of the serial peripheral on both channels.
   assumes 8 data bits, no parity, 16 serial clocks a bit; lines idle high. */
`timescale 1ns/1ps
module tsc_peer
(
    // serial clock source
    input wire logic serial_clk,
    // grants as commanded by the bench
    input wire logic [1:0] grant_on,
    // device pins
    input wire logic serial_out_ch0,
    input wire logic serial_out_ch1,
    output logic serial_in_ch0,
    output logic serial_in_ch1,
    output logic send_grant_ch0,
    output logic send_grant_ch1
);
    logic [7:0] last [2];
    int cnt [2];
    assign send_grant_ch0 = grant_on[0];
    assign send_grant_ch1 = grant_on[1];
    initial
    begin
        serial_in_ch0 = 1'b1;
        serial_in_ch1 = 1'b1;
        cnt[0] = 0;
        cnt[1] = 0;
    end
    task automatic send_byte(input int ch, input logic [7:0] b, input logic stop_lvl);
        logic [9:0] f;
        f = {stop_lvl, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge serial_clk);
            if (ch == 1)
                serial_in_ch1 = f[i];
            else
                serial_in_ch0 = f[i];
            repeat (15) @(negedge serial_clk);
        end
        // back to idle, also after a deliberately low stop bit
        if (ch == 1)
            serial_in_ch1 = 1'b1;
        else
            serial_in_ch0 = 1'b1;
    endtask
    // samples mid-bit, counted from the start bit's falling edge
    task automatic take(input int ch);
        logic [7:0] d;
        if (ch == 1)
            @(negedge serial_out_ch1);
        else
            @(negedge serial_out_ch0);
        repeat (8) @(posedge serial_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (16) @(posedge serial_clk);
            d[i] = (ch == 1) ? serial_out_ch1 : serial_out_ch0;
        end
        repeat (16) @(posedge serial_clk);
        last[ch] = d;
        cnt[ch]++;
    endtask
    always take(0);
    always take(1);
endmodule

// ===== dv/testbench.sv
/* self-checking bench for the twin serial channels.
   assumes the peer model in tsc_peer and a free running serial clock of 32 ns. */
`timescale 1ns/1ps
module testbench;
    logic clk_sys, nrst, serial_clk, si0, si1, gr0, gr1;
    logic [1:0] tx_valid, tx_ready, so, rq, grant_on;
    logic [1:0][7:0] tx_data;
    tsc_pkg::tsc_ctrl_t c0, c1;
    tsc_pkg::tsc_word_t rx0, rx1;
    int num_errors, compares;
    tsc_twin_serial_channels uut (.clk_sys(clk_sys), .nrst(nrst), .serial_clk(serial_clk),
        .ctrl_ch0(c0), .ctrl_ch1(c1), .tx_valid_ch0(tx_valid[0]), .tx_data_ch0(tx_data[0]),
        .tx_ready_ch0(tx_ready[0]), .tx_valid_ch1(tx_valid[1]), .tx_data_ch1(tx_data[1]),
        .tx_ready_ch1(tx_ready[1]), .rx_word_ch0(rx0), .rx_word_ch1(rx1),
        .serial_in_ch0(si0), .send_grant_ch0(gr0), .serial_out_ch0(so[0]),
        .send_request_ch0(rq[0]), .serial_in_ch1(si1), .send_grant_ch1(gr1),
        .serial_out_ch1(so[1]), .send_request_ch1(rq[1]));
    tsc_peer peer (.serial_clk(serial_clk), .grant_on(grant_on), .serial_out_ch0(so[0]),
        .serial_out_ch1(so[1]), .serial_in_ch0(si0), .serial_in_ch1(si1),
        .send_grant_ch0(gr0), .send_grant_ch1(gr1));
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial
    begin
        serial_clk = 1'b0;
        forever #16 serial_clk = ~serial_clk;
    end
    task close_out;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task fail(input string m);
        num_errors++;
        $display("mismatch at %0t: %s", $time, m);
        close_out();
    endtask
    task cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic push(input int ch, input logic [7:0] d);
        int n;
        @(negedge clk_sys);
        tx_valid[ch] = 1'b1;
        tx_data[ch] = d;
        for (n = 0; n < 4000 && tx_ready[ch] !== 1'b1; n++) @(negedge clk_sys);
        if (n == 4000) fail("word never taken");
        @(negedge clk_sys);
        tx_valid[ch] = 1'b0;
    endtask
    task automatic wait_frame(input int ch, input int k, input logic [7:0] e);
        int n;
        for (n = 0; n < 4000 && peer.cnt[ch] < k; n++) @(negedge clk_sys);
        if (n == 4000) fail("frame missing");
        cmp_byte(peer.last[ch], e);
    endtask
    task automatic wait_rx(input int ch, input logic [7:0] e);
        int n;
        for (n = 0; n < 4000 && (ch ? rx1.valid : rx0.valid) !== 1'b1; n++) @(negedge clk_sys);
        if (n == 4000) fail("word not received");
        cmp_byte(ch ? rx1.data : rx0.data, e);
    endtask
    task t_tx;
        fork
            push(0, 8'h1E);
            push(1, 8'h4D);
        join
        push(0, 8'h80);
        wait_frame(0, 1, 8'h1E);
        wait_frame(1, 1, 8'h4D);
        wait_frame(0, 2, 8'h80);
        $display("test tx done");
    endtask
    task t_grant;
        grant_on = 2'b00;
        push(0, 8'h36);
        repeat (1500) @(negedge clk_sys);
        cmp_bit(rq[0], 1'b1);
        cmp_bit(so[0], 1'b1);
        push(0, 8'h6C);
        cmp_bit(tx_ready[0], 1'b0);
        grant_on = 2'b11;
        wait_frame(0, 3, 8'h36);
        wait_frame(0, 4, 8'h6C);
        cmp_bit(rq[0], 1'b0);
        $display("test grant done");
    endtask
    task t_rx;
        fork
            peer.send_byte(0, 8'h2B, 1'b1);
            peer.send_byte(1, 8'h71, 1'b1);
            wait_rx(0, 8'h2B);
            wait_rx(1, 8'h71);
        join
        $display("test rx done");
    endtask
    task t_frame_err;
        int seen;
        seen = 0;
        fork
            peer.send_byte(0, 8'hA5, 1'b0);
            repeat (1500) @(negedge clk_sys) seen += int'(rx0.valid === 1'b1);
        join
        cmp_byte(8'(seen), 8'h00);
        fork
            peer.send_byte(0, 8'hC3, 1'b1);
            wait_rx(0, 8'hC3);
        join
        $display("test framing done");
    endtask
    task t_loop;
        c0.loopback = 1'b1;
        push(0, 8'h59);
        wait_rx(0, 8'h59);
        cmp_byte(8'(peer.cnt[0]), 8'h04);
        c0.loopback = 1'b0;
        $display("test loopback done");
    endtask
    task t_dis;
        c1.enable = 1'b0;
        push(1, 8'h0F);
        repeat (300) @(negedge clk_sys);
        cmp_bit(rq[1], 1'b0);
        cmp_bit(so[1], 1'b1);
        cmp_byte(8'(peer.cnt[1]), 8'h01);
        $display("test disable done");
    endtask
    initial
    begin
        nrst = 1'b0;
        c0 = 2'b10;
        c1 = 2'b10;
        tx_valid = 2'b00;
        tx_data = 16'h0000;
        grant_on = 2'b11;
        num_errors = 0;
        compares = 0;
        repeat (16) @(negedge clk_sys);
        cmp_bit(&so, 1'b1);
        cmp_bit(|rq, 1'b0);
        cmp_bit(&tx_ready, 1'b1);
        nrst = 1'b1;
        $display("test reset done");
        t_tx();
        t_grant();
        t_rx();
        t_frame_err();
        t_loop();
        t_dis();
        close_out();
    end
endmodule
